// [design/input_sync_edge.sv]
// Two-stage synchroniser with rising-edge detection for a group of pins.
// Assumes the inputs are asynchronous to i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module input_sync_edge #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Pins
    input wire logic [WIDTH-1:0] i_pins,
    // Synchronised results
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end
        else if (i_clk_en)
        begin
            meta <= i_pins;
            stable <= meta;
            prev <= stable;
        end
    end

    assign o_level = stable;
    // One pulse per rising transition, only once the level has settled
    assign o_rise = stable & ~prev;
endmodule
`default_nettype wire

// [design/iso_irq_map.svh]
// Register offsets, field positions, reset values and line codes of the isolated input interrupt router.
// Assumes a 32-byte I/O window and 16-bit host accesses.
`ifndef ISO_IRQ_MAP_SVH
`define ISO_IRQ_MAP_SVH

// ****************************************************************
// Byte offsets inside the I/O window
// ****************************************************************
`define MAP_OFS_GLOBAL 5'h02
`define MAP_OFS_CONTROL 5'h04
`define MAP_OFS_GATE 5'h06
`define MAP_OFS_CAPTURE 5'h08
`define MAP_OFS_SEL_FIRST 5'h0A
`define MAP_OFS_SEL_SECOND 5'h0C
`define MAP_OFS_SEL_THIRD 5'h0E

// ****************************************************************
// Field positions
// ****************************************************************
`define MAP_BIT_CLR_LOW 0
`define MAP_BIT_CLR_HIGH 1
`define MAP_BIT_ANY_LOW 4
`define MAP_BIT_ANY_HIGH 5
`define MAP_BIT_GATE_LOW 6
`define MAP_BIT_GATE_HIGH 7
`define MAP_CODE_WIDTH 3

// ****************************************************************
// Reset values
// ****************************************************************
`define MAP_RST_WORD 16'h0000
`define MAP_RST_CTRL 8'h00
`define MAP_RST_CLR_BITS 2'h3

// ****************************************************************
// Select code to bus line
// ****************************************************************
`define MAP_LINE_CODE0 4'hA
`define MAP_LINE_CODE1 4'hB
`define MAP_LINE_CODE2 4'hC
`define MAP_LINE_CODE3 4'hF
`define MAP_LINE_CODE4 4'h2
`define MAP_LINE_CODE5 4'h7
`define MAP_LINE_CODE6 4'h5
`define MAP_LINE_CODE7 4'h3

`endif

// [design/iso_irq_pkg.sv]
// Types shared by the isolated input interrupt router.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package iso_irq_pkg;
    typedef logic [2:0] irq_code_t;
    typedef logic [3:0] irq_line_t;
    typedef logic [15:0] word_t;
endpackage
`default_nettype wire

// [design/iso_irq_router.sv]
// Interrupt routing and edge capture for sixteen isolated inputs behind a 16-bit I/O window.
// Assumes host strobes, address and data are asynchronous pins held for at least three clocks.
`timescale 1ns/100ps
`default_nettype none
`include "iso_irq_map.svh"
module iso_irq_router (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Host I/O bus
    input wire logic [4:0] i_addr,
    input wire logic i_ior_n,
    input wire logic i_iow_n,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic o_data_oe,
    // Isolated inputs
    input wire logic [15:0] i_iso_in,
    // Bus interrupt lines
    output logic [15:0] o_irq_line,
    output logic [15:0] o_irq_oe,
    output logic o_shared_irq
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic iso_irq_pkg::irq_line_t line_of(input iso_irq_pkg::irq_code_t code);
        case (code)
            3'h0: line_of = `MAP_LINE_CODE0;
            3'h1: line_of = `MAP_LINE_CODE1;
            3'h2: line_of = `MAP_LINE_CODE2;
            3'h3: line_of = `MAP_LINE_CODE3;
            3'h4: line_of = `MAP_LINE_CODE4;
            3'h5: line_of = `MAP_LINE_CODE5;
            3'h6: line_of = `MAP_LINE_CODE6;
            3'h7: line_of = `MAP_LINE_CODE7;
            default: line_of = `MAP_LINE_CODE0;
        endcase
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [15:0] in_level;
    logic [15:0] in_rise;
    logic [20:0] bus_level;
    logic [1:0] strobe_level;
    logic [1:0] strobe_rise;

    // Inputs settle before edges are taken
    input_sync_edge #(.WIDTH(16)) u_iso_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_pins(i_iso_in),
        .o_level(in_level),
        .o_rise(in_rise)
    );

    // Address and data share the strobe latency so they are valid together
    input_sync_edge #(.WIDTH(21)) u_bus_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_pins({i_addr, i_data}),
        .o_level(bus_level),
        .o_rise()
    );

    input_sync_edge #(.WIDTH(2)) u_strobe_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_pins({~i_ior_n, ~i_iow_n}),
        .o_level(strobe_level),
        .o_rise(strobe_rise)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire [4:0] word_addr = {bus_level[20:17], 1'b0};
    wire [15:0] wr_data = bus_level[15:0];
    wire rd_start = strobe_rise[1];
    wire rd_active = strobe_level[1];
    wire wr_take = strobe_rise[0];
    wire hit_global = (word_addr == `MAP_OFS_GLOBAL);
    wire hit_control = (word_addr == `MAP_OFS_CONTROL);
    wire hit_gate = (word_addr == `MAP_OFS_GATE);
    wire hit_capture = (word_addr == `MAP_OFS_CAPTURE);
    wire hit_sel_first = (word_addr == `MAP_OFS_SEL_FIRST);
    wire hit_sel_second = (word_addr == `MAP_OFS_SEL_SECOND);
    wire hit_sel_third = (word_addr == `MAP_OFS_SEL_THIRD);

    // ****************************************************************
    // Registers
    // ****************************************************************
    iso_irq_pkg::word_t gate;
    iso_irq_pkg::word_t sel_first;
    iso_irq_pkg::word_t sel_second;
    iso_irq_pkg::word_t sel_third;
    iso_irq_pkg::word_t edge_capture;
    logic [7:0] control;
    logic [1:0] clr_bits;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gate <= `MAP_RST_WORD;
            sel_first <= `MAP_RST_WORD;
            sel_second <= `MAP_RST_WORD;
            sel_third <= `MAP_RST_WORD;
            control <= `MAP_RST_CTRL;
            clr_bits <= `MAP_RST_CLR_BITS;
        end
        else if (i_clk_en && wr_take)
        begin
            if (hit_gate)
                gate <= wr_data;
            if (hit_sel_first)
                sel_first <= wr_data;
            if (hit_sel_second)
                sel_second <= wr_data;
            if (hit_sel_third)
                sel_third <= wr_data;
            if (hit_control)
                control <= wr_data[7:0];
            if (hit_global)
                clr_bits <= wr_data[`MAP_BIT_CLR_HIGH:`MAP_BIT_CLR_LOW];
        end
    end

    // ****************************************************************
    // Edge capture and group clear
    // ****************************************************************
    // A clear only fires on a 1 that follows a written 0; a reset state of 1s keeps the first 1 harmless
    wire clr_low = wr_take && hit_global && wr_data[`MAP_BIT_CLR_LOW]
        && !clr_bits[`MAP_BIT_CLR_LOW];
    wire clr_high = wr_take && hit_global && wr_data[`MAP_BIT_CLR_HIGH]
        && !clr_bits[`MAP_BIT_CLR_HIGH];
    wire [15:0] clr_mask = {{8{clr_high}}, {8{clr_low}}};
    // An edge in the clearing cycle survives the clear
    wire [15:0] next_capture = (edge_capture & ~clr_mask) | in_rise;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            edge_capture <= `MAP_RST_WORD;
        else if (i_clk_en)
            edge_capture <= next_capture;
    end

    // ****************************************************************
    // Shared interrupt
    // ****************************************************************
    wire any_low = |edge_capture[7:0];
    wire any_high = |edge_capture[15:8];
    wire next_shared = (any_low && control[`MAP_BIT_GATE_LOW])
        || (any_high && control[`MAP_BIT_GATE_HIGH]);

    // ****************************************************************
    // Per-input routing
    // ****************************************************************
    // Select fields run back to back across the three registers, so fields 5 and 10 straddle
    wire [47:0] sel_all = {sel_third, sel_second, sel_first};
    logic [15:0] next_irq_line;
    logic [15:0] next_irq_oe;

    always_comb
    begin
        next_irq_line = 16'h0000;
        next_irq_oe = 16'h0000;
        for (int n = 0; n < 16; n++)
        begin
            if (gate[n])
            begin
                next_irq_oe[line_of(sel_all[n*`MAP_CODE_WIDTH +: `MAP_CODE_WIDTH])] = 1'b1;
                if (in_level[n])
                    next_irq_line[line_of(sel_all[n*`MAP_CODE_WIDTH +: `MAP_CODE_WIDTH])] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [15:0] global_read = {10'h000, any_high, any_low, 2'h0, clr_bits};
    wire [15:0] next_rd_data =
        hit_global ? global_read :
        hit_control ? {8'h00, control} :
        hit_gate ? gate :
        hit_capture ? edge_capture :
        hit_sel_first ? sel_first :
        hit_sel_second ? sel_second :
        hit_sel_third ? sel_third : 16'h0000;

    // ****************************************************************
    // Output stage
    // ****************************************************************
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_data <= `MAP_RST_WORD;
            o_data_oe <= 1'b0;
            o_irq_line <= `MAP_RST_WORD;
            o_irq_oe <= `MAP_RST_WORD;
            o_shared_irq <= 1'b0;
        end
        else if (i_clk_en)
        begin
            // Whole word latched at once so a read never tears the capture bits
            if (rd_start)
                o_data <= next_rd_data;
            o_data_oe <= rd_active;
            o_irq_line <= next_irq_line;
            o_irq_oe <= next_irq_oe;
            o_shared_irq <= next_shared;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    wire [3:0] line0 = line_of(sel_first[2:0]);
    wire [3:0] line5 = line_of({sel_second[1:0], sel_first[15]});

    a_gate_off_quiet: assert property (
        (i_clk_en && gate == 16'h0000) |=> (o_irq_oe == 16'h0000))
        else $error("Line driven with all gates off");

    a_route_input0: assert property (
        (i_clk_en && gate[0] && in_level[0]) |=> o_irq_line[$past(line0)])
        else $error("Input 0 not routed to its line");

    a_decode_code3: assert property (
        (i_clk_en && gate == 16'h0001 && sel_first[2:0] == 3'h3) |=> (o_irq_oe == 16'h8000))
        else $error("Code 3 does not select line 15");

    a_split_input5: assert property (
        (i_clk_en && gate == 16'h0020 && in_level[5]) |=> o_irq_line[$past(line5)])
        else $error("Input 5 split field decoded wrongly");

    a_gate_readback: assert property (
        (i_clk_en && rd_start && hit_gate) |=> (o_data == $past(gate)))
        else $error("Gate register readback mismatch");

    a_capture_low: assert property (
        (i_clk_en && in_rise[3]) |=> edge_capture[3] ##1 (edge_capture[3] || $past(i_clk_en && clr_low)))
        else $error("Low edge not latched");

    a_capture_high: assert property (
        (i_clk_en && in_rise[9]) |=> edge_capture[9])
        else $error("High edge not latched");

    a_clear_low: assert property (
        (i_clk_en && clr_low && in_rise[7:0] == 8'h00) |=> (edge_capture[7:0] == 8'h00))
        else $error("Low flags survive the clear");

    a_clear_high: assert property (
        (i_clk_en && clr_high && in_rise[15:8] == 8'h00) |=> (edge_capture[15:8] == 8'h00))
        else $error("High flags survive the clear");

    a_shared_low: assert property (
        (i_clk_en && any_low && control[`MAP_BIT_GATE_LOW]) |=> o_shared_irq)
        else $error("Shared interrupt missing for low flags");

    a_shared_blocked: assert property (
        (i_clk_en && !control[`MAP_BIT_GATE_LOW] && !control[`MAP_BIT_GATE_HIGH]) |=> !o_shared_irq)
        else $error("Shared interrupt with both group gates off");

    a_shared_high: assert property (
        (i_clk_en && any_high && !any_low && control[`MAP_BIT_GATE_HIGH]) |=> o_shared_irq)
        else $error("Shared interrupt missing for high flags");

    // ****************************************************************
    // Field placement and holding checks
    // ****************************************************************
    a_decode_code0: assert property (
        (i_clk_en && gate == 16'h0001 && sel_first[2:0] == 3'h0) |=> (o_irq_oe == 16'h0400))
        else $error("Code 0 does not select line 10");

    a_route_input2: assert property (
        (i_clk_en && gate == 16'h0004 && in_level[2] && sel_first[8:6] == 3'h2) |=> (o_irq_line == 16'h1000))
        else $error("Input 2 field decoded wrongly");

    a_route_input4: assert property (
        (i_clk_en && gate == 16'h0010 && in_level[4] && sel_first[14:12] == 3'h4) |=> (o_irq_line == 16'h0004))
        else $error("Input 4 field decoded wrongly");

    a_route_input6: assert property (
        (i_clk_en && gate == 16'h0040 && in_level[6] && sel_second[4:2] == 3'h6) |=> (o_irq_line == 16'h0020))
        else $error("Input 6 field decoded wrongly");

    a_route_input7: assert property (
        (i_clk_en && gate == 16'h0080 && in_level[7] && sel_second[7:5] == 3'h7) |=> (o_irq_line == 16'h0008))
        else $error("Input 7 field decoded wrongly");

    a_route_input9: assert property (
        (i_clk_en && gate == 16'h0200 && in_level[9] && sel_second[13:11] == 3'h1) |=> (o_irq_line == 16'h0800))
        else $error("Input 9 field decoded wrongly");

    a_split_input10: assert property (
        (i_clk_en && gate == 16'h0400 && in_level[10] && {sel_third[0], sel_second[15:14]} == 3'h6)
        |=> (o_irq_line == 16'h0020))
        else $error("Input 10 split field decoded wrongly");

    a_route_input15: assert property (
        (i_clk_en && gate == 16'h8000 && in_level[15] && sel_third[15:13] == 3'h7) |=> (o_irq_line == 16'h0008))
        else $error("Input 15 field decoded wrongly");

    a_gate_off_lines: assert property (
        (i_clk_en && gate == 16'h0000) |=> (o_irq_line == 16'h0000))
        else $error("Line level shown with all gates off");

    a_capture_sticky: assert property (
        (i_clk_en && edge_capture[0] && !clr_low) |=> edge_capture[0])
        else $error("Low flag lost without a clear");

    // Only a 1 after a written 0 may clear
    a_clear_armed: assert property (
        (i_clk_en && wr_take && hit_global && clr_bits[`MAP_BIT_CLR_LOW])
        |=> ((edge_capture[7:0] & $past(edge_capture[7:0])) == $past(edge_capture[7:0])))
        else $error("Low flags cleared without a written 0 first");

    a_shared_idle: assert property (
        (i_clk_en && !any_low && !any_high) |=> !o_shared_irq)
        else $error("Shared interrupt with no flag set");

    a_freeze_hold: assert property (
        (!i_clk_en) |=> ($stable(edge_capture) && $stable(o_shared_irq)))
        else $error("State moved with clock enable low");

    c_edge_captured: cover property (i_clk_en && in_rise[0] ##1 edge_capture[0]);
    c_low_cleared: cover property (i_clk_en && clr_low && any_low);
    c_shared_raised: cover property ($rose(o_shared_irq));
    c_line_routed: cover property ($rose(o_irq_line[10]));
    c_high_cleared: cover property (i_clk_en && clr_high && any_high);
endmodule
`default_nettype wire

// [test/isa_host_model.sv]
// Host side of the I/O bus: strobed 16-bit word reads and writes.
// Assumes the router passes strobes through two flops on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module isa_host_model (
    // Clock
    input wire logic i_ref_clk,
    // Router read side
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_oe,
    // Bus drive
    output logic [4:0] o_addr,
    output logic o_ior_n,
    output logic o_iow_n,
    output logic [15:0] o_data
);
    initial
    begin
        o_addr = 5'h00;
        o_ior_n = 1'b1;
        o_iow_n = 1'b1;
        o_data = 16'h0000;
    end

    // Strobe held four edges, then four idle edges before the next access
    task automatic write_word(input logic [4:0] addr, input logic [15:0] data);
        @(posedge i_ref_clk);
        o_addr <= addr;
        o_data <= data;
        o_iow_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        o_iow_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        // Released bus must not keep showing the old word
        o_data <= ~data;
    endtask

    // Whole word in one access, never two byte reads
    task automatic read_word(input logic [4:0] addr, output logic [15:0] data);
        @(posedge i_ref_clk);
        o_addr <= addr;
        o_ior_n <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        data = i_rd_oe ? i_rd_data : ~i_rd_data;
        o_ior_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the isolated input interrupt router.
// Assumes the host model file is compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "iso_irq_map.svh"
module testbench;
    logic i_ref_clk;
    logic i_rst;
    logic clk_en;
    logic [15:0] i_iso_in;
    logic [4:0] bus_addr;
    logic bus_ior_n;
    logic bus_iow_n;
    logic [15:0] bus_wdata;
    logic [15:0] o_data;
    logic o_data_oe;
    logic [15:0] o_irq_line;
    logic [15:0] o_irq_oe;
    logic o_shared_irq;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam int line_of[8] = '{10, 11, 12, 15, 2, 7, 5, 3};

    iso_irq_router dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(clk_en), .i_addr(bus_addr),
        .i_ior_n(bus_ior_n), .i_iow_n(bus_iow_n), .i_data(bus_wdata), .o_data(o_data),
        .o_data_oe(o_data_oe), .i_iso_in(i_iso_in), .o_irq_line(o_irq_line), .o_irq_oe(o_irq_oe),
        .o_shared_irq(o_shared_irq));
    isa_host_model host (.i_ref_clk(i_ref_clk), .i_rd_data(o_data), .i_rd_oe(o_data_oe),
        .o_addr(bus_addr), .o_ior_n(bus_ior_n), .o_iow_n(bus_iow_n), .o_data(bus_wdata));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check_word(input string name, input iso_irq_pkg::word_t exp, input iso_irq_pkg::word_t got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic rd_check(input logic [4:0] addr, input iso_irq_pkg::word_t exp, input string name);
        iso_irq_pkg::word_t got;
        host.read_word(addr, got);
        check_word(name, exp, got);
    endtask

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, far above the expected thirteen hundred or so cycles
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic drive_inputs(input iso_irq_pkg::word_t value, input int hold);
        @(posedge i_ref_clk);
        i_iso_in <= value;
        repeat (hold) @(posedge i_ref_clk);
    endtask

    // Mask bit0 clears the low byte, bit1 the high byte
    task automatic clear_flags(input logic [1:0] mask);
        host.write_word(`MAP_OFS_GLOBAL, {14'h0000, ~mask});
        host.write_word(`MAP_OFS_GLOBAL, 16'h0003);
    endtask

    task automatic test_reset();
        rd_check(`MAP_OFS_GATE, 16'h0000, "gate_reset");
        rd_check(`MAP_OFS_SEL_FIRST, 16'h0000, "sel_first_reset");
        rd_check(`MAP_OFS_SEL_SECOND, 16'h0000, "sel_second_reset");
        rd_check(`MAP_OFS_SEL_THIRD, 16'h0000, "sel_third_reset");
        check_word("irq_oe_reset", 16'h0000, o_irq_oe);
        check_bit("data_oe_idle", 1'b0, o_data_oe);
        host.write_word(5'h10, 16'hFFFF);
        host.write_word(`MAP_OFS_CAPTURE, 16'hFFFF);
        rd_check(5'h10, 16'h0000, "unmapped");
        rd_check(`MAP_OFS_CAPTURE, 16'h0000, "capture_ro");
        host.write_word(`MAP_OFS_GATE, 16'hA5C3);
        rd_check(`MAP_OFS_GATE, 16'hA5C3, "gate_readback");
    endtask

    // Code placed at bits 3n+2..3n of the three select words taken as one
    task automatic test_route(input int n, input logic [2:0] code, input logic gate);
        logic [47:0] sel;
        iso_irq_pkg::word_t exp;
        sel = 48'(code) << (3 * n);
        host.write_word(`MAP_OFS_SEL_FIRST, sel[15:0]);
        host.write_word(`MAP_OFS_SEL_SECOND, sel[31:16]);
        host.write_word(`MAP_OFS_SEL_THIRD, sel[47:32]);
        host.write_word(`MAP_OFS_GATE, 16'(gate) << n);
        exp = gate ? 16'h0001 << line_of[code] : 16'h0000;
        drive_inputs(16'h0001 << n, 5);
        check_word("irq_line", exp, o_irq_line);
        check_word("irq_oe", exp, o_irq_oe);
        drive_inputs(16'h0000, 5);
        check_word("irq_line_idle", 16'h0000, o_irq_line);
    endtask

    task automatic test_capture();
        clear_flags(2'h3);
        rd_check(`MAP_OFS_CAPTURE, 16'h0000, "capture_clear_all");
        drive_inputs(16'h8003, 5);
        // Input 1 stays high through the clears
        drive_inputs(16'h0002, 5);
        rd_check(`MAP_OFS_CAPTURE, 16'h8003, "capture_set");
        clear_flags(2'h1);
        rd_check(`MAP_OFS_CAPTURE, 16'h8000, "capture_low_clear");
        clear_flags(2'h2);
        rd_check(`MAP_OFS_CAPTURE, 16'h0000, "capture_high_clear");
        drive_inputs(16'h0000, 5);
    endtask

    task automatic test_shared();
        host.write_word(`MAP_OFS_CONTROL, 16'h0040);
        drive_inputs(16'h0100, 3);
        drive_inputs(16'h0000, 5);
        check_bit("shared_high_blocked", 1'b0, o_shared_irq);
        drive_inputs(16'h0001, 3);
        drive_inputs(16'h0000, 5);
        check_bit("shared_low", 1'b1, o_shared_irq);
        host.write_word(`MAP_OFS_CONTROL, 16'h0080);
        check_bit("shared_high", 1'b1, o_shared_irq);
        clear_flags(2'h2);
        check_bit("shared_low_blocked", 1'b0, o_shared_irq);
        host.write_word(`MAP_OFS_CONTROL, 16'h0040);
        check_bit("shared_low_again", 1'b1, o_shared_irq);
        clear_flags(2'h1);
        check_bit("shared_cleared", 1'b0, o_shared_irq);
    endtask

    // Edge arriving while frozen must wait until the clock enable returns
    task automatic test_freeze();
        @(posedge i_ref_clk);
        clk_en <= 1'b0;
        drive_inputs(16'h0010, 8);
        check_bit("shared_frozen", 1'b0, o_shared_irq);
        @(posedge i_ref_clk);
        clk_en <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        check_bit("shared_after_freeze", 1'b1, o_shared_irq);
        drive_inputs(16'h0000, 5);
        clear_flags(2'h1);
        rd_check(`MAP_OFS_CAPTURE, 16'h0000, "capture_after_freeze");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        i_rst = 1'b1;
        i_iso_in = 16'h0000;
        clk_en = 1'b1;
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        test_reset();
        for (int n = 0; n < 16; n++)
            test_route(n, n[2:0], 1'b1);
        test_route(5, 3'h5, 1'b0);
        test_route(10, 3'h6, 1'b1);
        test_route(0, 3'h3, 1'b1);
        test_capture();
        test_shared();
        test_freeze();
        finish_test();
    end
endmodule
`default_nettype wire
